//--- common/rxf_pkg.sv
package rxf_pkg;
  // Register byte offsets.
  localparam logic [7:0] RXF_FILTER_ENABLE_OFS = 8'h00;
  localparam logic [7:0] RXF_MAX_LEN_OFS = 8'h04;
  localparam logic [7:0] RXF_SOF_OVR_OFS = 8'h08;
  localparam logic [7:0] RXF_MOF_OVR_OFS = 8'h0c;
  localparam logic [7:0] RXF_DMA_OVR_OFS = 8'h10;
  localparam logic [7:0] RXF_LAST_DEC_OFS = 8'h14;
  localparam logic [7:0] RXF_CHAN_EN_OFS = 8'h18;
  // Field positions in the filter enable register.
  localparam int RXF_PROM_CH_LSB = 0;
  localparam int RXF_CAF_BIT = 3;
  localparam int RXF_CEF_BIT = 4;
  localparam int RXF_CMF_BIT = 5;
  localparam int RXF_CSF_BIT = 6;
  // Reset values, minimum frame length and response codes.
  localparam logic [31:0] RXF_FILTER_ENABLE_RST = 32'h0000_0000;
  localparam logic [15:0] RXF_MAX_LEN_RST = 16'h05ee;
  localparam logic [7:0] RXF_CHAN_EN_RST = 8'hff;
  localparam logic [15:0] RXF_MIN_LEN = 16'h0040;
  localparam logic [1:0] RXF_RESP_OKAY = 2'b00;
  localparam logic [1:0] RXF_RESP_SLVERR = 2'b10;
  // Overrun kinds on the overrun event input.
  typedef enum logic [1:0] {
    RXF_OVR_FIFO_SOF,
    RXF_OVR_FIFO_MOF,
    RXF_OVR_DMA_SOF,
    RXF_OVR_DMA_MOF
  } rxf_ovr_kind_t;
  typedef enum logic [1:0] {RXF_IDLE, RXF_FRAME, RXF_DROP} rxf_state_t;
endpackage

//--- testbench/rxf_filter_properties.sv
`timescale 1ns/1ps
module rxf_filter_properties
  import rxf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic rx_clk,
  input wire logic rx_clk_rise,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic [15:0] frame_length,
  input wire logic overrun_event,
  input wire logic [1:0] overrun_kind,
  input wire logic frame_deliver,
  input wire logic frame_drop,
  input wire logic [2:0] frame_channel,
  input wire logic frame_truncate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic sof_pend;
  // Remembers a frame refused at its start until that frame ends.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sof_pend <= 1'b0;
    end else if (frame_start) begin
      sof_pend <= overrun_event && !overrun_kind[0];
    end else if (frame_end) begin
      sof_pend <= 1'b0;
    end
  end
  property p_sof_drop;
    sof_pend && frame_end |=> frame_drop && !frame_deliver;
  endproperty
  a_sof_drop: assert property (p_sof_drop) else $error("start overrun not dropped");
  property p_dlv_cause;
    frame_deliver |-> $past(frame_end);
  endproperty
  a_dlv_cause: assert property (p_dlv_cause) else $error("delivery without frame end");
  property p_drop_cause;
    frame_drop |-> $past(frame_end);
  endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("drop without cause");
  property p_excl;
    !(frame_deliver && frame_drop);
  endproperty
  a_excl: assert property (p_excl) else $error("deliver and drop together");
  property p_hold;
    !frame_deliver && !frame_drop |-> $stable(frame_channel);
  endproperty
  a_hold: assert property (p_hold) else $error("channel moved between decisions");
  property p_rise;
    $rose(rx_clk) |-> ##[1:4] rx_clk_rise;
  endproperty
  a_rise: assert property (p_rise) else $error("link clock edge missed");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_trunc;
    frame_truncate |-> $past(frame_length) >= RXF_MAX_LEN_RST;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncation below maximum");
endmodule // rxf_filter_properties

bind rxf_filter rxf_filter_properties i_rxf_filter_properties (.clk, .rst_b, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rx_clk,
  .rx_clk_rise, .frame_start, .frame_end, .frame_length, .overrun_event, .overrun_kind,
  .frame_deliver, .frame_drop, .frame_channel, .frame_truncate);

//--- testbench/rxf_filter_test.sv
`timescale 1ns/1ps
module rxf_filter_test
  import rxf_pkg::*;
;
  logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, overrun_kind, r;
  logic rx_clk, frame_start, frame_dest_hit, frame_is_control, frame_end, frame_code_error;
  logic frame_align_error, frame_crc_error, overrun_event, frame_deliver, frame_drop;
  logic desc_overrun_flag, desc_unmatched_flag, frame_truncate, rx_clk_rise;
  logic [2:0] frame_dest_channel, frame_channel;
  logic [15:0] frame_length;
  int num_errors = 0, n_checks = 0, n_dlv = 0, n_drp = 0, n_trn = 0, n_rr = 0;
  localparam logic [15:0] LEN [8] = '{16'h05ee, 16'h003f, 16'h0028, 16'h05ef, 16'h0640,
    16'h0064, 16'h05ee, 16'h0040};
  localparam logic [2:0] ERR [8] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h4, 3'h2, 3'h1, 3'h0};
  rxf_filter i_rxf_filter (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_clk, .frame_start, .frame_dest_channel, .frame_dest_hit,
    .frame_is_control, .frame_end, .frame_length, .frame_code_error, .frame_align_error,
    .frame_crc_error, .overrun_event, .overrun_kind, .frame_deliver, .frame_channel,
    .frame_drop, .desc_overrun_flag, .desc_unmatched_flag, .frame_truncate, .rx_clk_rise);
  rxf_phy_model i_rxf_phy_model (.clk, .rx_clk, .frame_start, .frame_dest_channel,
    .frame_dest_hit, .frame_is_control, .frame_end, .frame_length, .frame_code_error,
    .frame_align_error, .frame_crc_error, .overrun_event, .overrun_kind);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (frame_deliver) n_dlv <= n_dlv + 1;
    if (frame_drop) n_drp <= n_drp + 1;
    if (frame_truncate) n_trn <= n_trn + 1;
    if (rx_clk_rise) n_rr <= n_rr + 1;
  end
  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // Bits of en are short, control, error, all from high to low.
  function automatic logic acc(input logic m, input logic [3:0] en, input int c);
    if (!m && !en[0]) return 1'b0;
    case (c)
      0: return 1'b1;
      1: return en[3];
      2: return en[3] && en[1];
      7: return en[2];
      default: return en[1];
    endcase
  endfunction
  task automatic frm(input logic [2:0] dch, input logic hit, input int c, input logic ov,
    input logic [1:0] ok, input logic xd, input logic [2:0] xch);
    int d0, x0, t0;
    d0 = n_dlv;
    x0 = n_drp;
    t0 = n_trn;
    i_rxf_phy_model.send(dch, hit, c == 7, LEN[c], ERR[c], ov, ok);
    #1;
    chk(n_dlv - d0, 32'(xd));
    chk(32'(n_drp != x0), 32'(!xd));
    // A frame refused at its start is never received, so it is never cut either.
    chk(32'(n_trn != t0), 32'(LEN[c] >= RXF_MAX_LEN_RST && !(ov && !ok[0])));
    if (xd) chk(32'(frame_channel), 32'(xch));
  endtask
  initial begin
    logic [3:0] en;
    logic mt;
    logic [1:0] ok;
    // Both response ready lines stay high, so each answer is taken at the edge it is seen.
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(RXF_FILTER_ENABLE_OFS, RXF_FILTER_ENABLE_RST, RXF_RESP_OKAY);
    rchk(RXF_MAX_LEN_OFS, 32'(RXF_MAX_LEN_RST), RXF_RESP_OKAY);
    rchk(RXF_CHAN_EN_OFS, 32'(RXF_CHAN_EN_RST), RXF_RESP_OKAY);
    rchk(8'h1c, 32'h0, RXF_RESP_SLVERR);
    wr(8'h1c, 32'h0000_00ff);
    chk(32'(r), 32'(RXF_RESP_SLVERR));
    for (int e = 0; e < 16; e++) begin
      en = 4'(e);
      wr(RXF_FILTER_ENABLE_OFS, {25'h0, en, en[2:0]});
      for (int m = 0; m < 2; m++) begin
        for (int c = 0; c < 8; c++) begin
          mt = m[0] && (c != 7 || en[2]);
          frm(~en[2:0], m[0], c, 1'b0, 2'h0, acc(mt, en, c),
            mt ? ~en[2:0] : en[2:0]);
        end
      end
    end
    wr(RXF_CHAN_EN_OFS, 32'h0000_00fb);
    wr(RXF_FILTER_ENABLE_OFS, 32'h0000_000d);
    frm(3'h2, 1'b1, 0, 1'b0, 2'h0, 1'b1, 3'h5);
    wr(RXF_CHAN_EN_OFS, 32'h0000_00ff);
    for (int k = 0; k < 4; k++) begin
      ok = 2'(k);
      for (int cf = 0; cf < 4; cf++) begin
        wr(RXF_FILTER_ENABLE_OFS, {27'h0, cf[0], 4'hd});
        frm(3'h2, cf[1], 0, 1'b1, ok, ok[0] && cf[0],
          cf[1] ? 3'h2 : 3'h5);
        if (ok[0] && cf[0]) begin
          chk(32'(desc_overrun_flag), 32'h1);
          chk(32'(desc_unmatched_flag), 32'(!cf[1]));
        end
      end
    end
    rchk(RXF_SOF_OVR_OFS, 32'h8, RXF_RESP_OKAY);
    rchk(RXF_MOF_OVR_OFS, 32'h8, RXF_RESP_OKAY);
    rchk(RXF_DMA_OVR_OFS, 32'h8, RXF_RESP_OKAY);
    chk(n_rr, i_rxf_phy_model.n_rise);
    complete_run();
  end
  initial begin
    #3000000;
    num_errors++;
    complete_run();
  end
endmodule // rxf_filter_test

//--- testbench/rxf_phy_model.sv
`timescale 1ns/1ps
module rxf_phy_model (
  input wire logic clk,
  output logic rx_clk,
  output logic frame_start,
  output logic [2:0] frame_dest_channel,
  output logic frame_dest_hit,
  output logic frame_is_control,
  output logic frame_end,
  output logic [15:0] frame_length,
  output logic frame_code_error,
  output logic frame_align_error,
  output logic frame_crc_error,
  output logic overrun_event,
  output logic [1:0] overrun_kind
);
  logic busy = 1'b0;
  int n_rise = 0;
  initial begin
    rx_clk = 1'b0;
    {frame_start, frame_end, overrun_event} = 3'h0;
    {frame_dest_channel, frame_dest_hit, frame_is_control} = 5'h00;
    {frame_code_error, frame_align_error, frame_crc_error, overrun_kind} = 5'h00;
    frame_length = 16'h0000;
    #137;
    forever begin
      #400;
      if (busy) rx_clk = ~rx_clk;
    end
  end
  always @(posedge rx_clk) n_rise++;
  // Fields not sampled any more are inverted so stale values are never seen.
  task automatic send(input logic [2:0] dch, input logic hit, input logic ctl,
    input logic [15:0] len, input logic [2:0] err, input logic ov, input logic [1:0] ok);
    logic [15:0] n;
    n = 16'h0000;
    @(posedge clk);
    busy = 1'b1;
    frame_start <= 1'b1;
    {frame_dest_channel, frame_dest_hit, frame_is_control} <= {dch, hit, ctl};
    frame_length <= n;
    overrun_kind <= ok;
    overrun_event <= ov && !ok[0];
    for (int i = 0; n < len || i < 3; i++) begin
      @(posedge clk);
      frame_start <= 1'b0;
      {frame_dest_channel, frame_dest_hit, frame_is_control} <= ~{dch, hit, ctl};
      n = (len - n > 16'h0040) ? n + 16'h0040 : len;
      frame_length <= n;
      overrun_event <= ov && ok[0] && i == 1;
    end
    @(posedge clk);
    frame_end <= 1'b1;
    {frame_code_error, frame_align_error, frame_crc_error} <= err;
    @(posedge clk);
    frame_end <= 1'b0;
    {frame_code_error, frame_align_error, frame_crc_error} <= ~err;
    frame_length <= ~len;
    busy = 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // rxf_phy_model

//--- verilog/rxf_filter.sv
// What this block does
// - Accept-all set delivers non-matching frames to promiscuous channel; clear drops them.
// - Accept-all with accept-error delivers errored non-short matching frames to the match channel.
// - Only frames aimed at an enabled channel count as address matching.
// - Control frames address match only while accept-control is set.
// - Accept-error and accept-short govern storing, never the match decision.
// - Promiscuous frames all go to the channel chosen by the select field.
// - Proper means length 64 to maximum inclusive with no code, align, CRC error.
// - Non-matching with only accept-all: proper data frames delivered, all others dropped.
// - Accept-short admits undersized; with accept-error also fragments; both channels.
// - Accept-control admits control frames; without it control frames delivered only when kept after a middle overrun.
// - Accept-error admits oversize, jabber, code, align, CRC; short ones still need accept-short.
// - All four enables set deliver every non-matching frame not refused at its start to the promiscuous channel.
// - Matching frames ignore accept-all; with others clear only proper data frames pass.
// - Accept-error, control and short set deliver every matching frame not refused at its start.
// - Four overrun kinds feed start, middle and DMA overrun counters.
// - No resources at frame start counts the overrun and drops the frame.
// - Middle overrun drops by default; non-matching kept only with accept-all and accept-error.
// - Non-matching kept overrun goes promiscuous with overrun and unmatched flags set.
// - Matching overrun with accept-error goes to match channel with only overrun flag.
// - Matching overrun without accept-error is dropped yet still counted.
// - Overrun reported only before maximum length; longer frames truncate as oversize or jabber.
// - Maximum length resets to 1518; longer frames are oversize, or jabber with errors.
// - Short frames are undersized when clean, fragments with code, align or CRC errors.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module rxf_filter
  import rxf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_clk,
  input wire logic frame_start,
  input wire logic [2:0] frame_dest_channel,
  input wire logic frame_dest_hit,
  input wire logic frame_is_control,
  input wire logic frame_end,
  input wire logic [15:0] frame_length,
  input wire logic frame_code_error,
  input wire logic frame_align_error,
  input wire logic frame_crc_error,
  input wire logic overrun_event,
  input wire logic [1:0] overrun_kind,
  output logic frame_deliver,
  output logic [2:0] frame_channel,
  output logic frame_drop,
  output logic desc_overrun_flag,
  output logic desc_unmatched_flag,
  output logic frame_truncate,
  output logic rx_clk_rise
);

  typedef struct packed {
    logic [31:0] rx_filter_enable_reg;
    logic [15:0] rx_max_frame_length;
    logic [7:0] chan_enable;
    logic [31:0] start_overrun_counter;
    logic [31:0] midframe_overrun_counter;
    logic [31:0] dma_overrun_counter;
    logic [31:0] last_decision;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] rxclk_sync;
    rxf_state_t state;
    logic matched;
    logic ctl;
    logic [2:0] dest_ch;
    logic overrun_seen;
    logic deliver;
    logic [2:0] channel;
    logic drop;
    logic ovr_flag;
    logic desc_unmatched_flag_flag;
    logic truncate;
  } rxf_state_s_t;

  rxf_state_s_t st_r;
  rxf_state_s_t st_nxt;

  logic caf;
  logic cef;
  logic cmf;
  logic csf;
  logic [2:0] prom_ch;
  logic addr_match;
  logic any_err;
  logic is_long;
  logic is_short;
  logic proper;
  logic admit;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  // Byte-lane merge of a write into a 32-bit register.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return (a == RXF_FILTER_ENABLE_OFS) || (a == RXF_MAX_LEN_OFS) ||
           (a == RXF_SOF_OVR_OFS) || (a == RXF_MOF_OVR_OFS) ||
           (a == RXF_DMA_OVR_OFS) || (a == RXF_LAST_DEC_OFS) || (a == RXF_CHAN_EN_OFS);
  endfunction

  always_comb begin
    caf = st_r.rx_filter_enable_reg[RXF_CAF_BIT];
    cef = st_r.rx_filter_enable_reg[RXF_CEF_BIT];
    cmf = st_r.rx_filter_enable_reg[RXF_CMF_BIT];
    csf = st_r.rx_filter_enable_reg[RXF_CSF_BIT];
    prom_ch = st_r.rx_filter_enable_reg[RXF_PROM_CH_LSB +: 3];
    // The match decision uses only channel enables and accept-control.
    addr_match = frame_dest_hit && st_r.chan_enable[frame_dest_channel] &&
                 (!frame_is_control || cmf);
    any_err = frame_code_error || frame_align_error || frame_crc_error;
    is_long = frame_length > st_r.rx_max_frame_length;
    is_short = frame_length < RXF_MIN_LEN;
    proper = !is_long && !is_short && !any_err;
    // Class admission, shared by both channels.
    if (proper) begin
      admit = 1'b1;
    end else if (is_short) begin
      admit = csf && (!any_err || cef);
    end else begin
      admit = cef;
    end
    // The control marking only stands at frame start, so the latched copy is used here.
    if (st_r.ctl && !cmf) begin
      admit = 1'b0;
    end
    if (st_r.matched) begin
      admit = admit || (caf && cef && !is_short);
    end else if (!caf) begin
      admit = 1'b0;
    end
    if (st_r.rvalid) begin
      rd_word = st_r.rdata;
    end
    rd_ok = 1'b1;
    if (s_axi_araddr == RXF_FILTER_ENABLE_OFS) begin
      rd_word = st_r.rx_filter_enable_reg;
    end else if (s_axi_araddr == RXF_MAX_LEN_OFS) begin
      rd_word = {16'h0000, st_r.rx_max_frame_length};
    end else if (s_axi_araddr == RXF_SOF_OVR_OFS) begin
      rd_word = st_r.start_overrun_counter;
    end else if (s_axi_araddr == RXF_MOF_OVR_OFS) begin
      rd_word = st_r.midframe_overrun_counter;
    end else if (s_axi_araddr == RXF_DMA_OVR_OFS) begin
      rd_word = st_r.dma_overrun_counter;
    end else if (s_axi_araddr == RXF_LAST_DEC_OFS) begin
      rd_word = st_r.last_decision;
    end else if (s_axi_araddr == RXF_CHAN_EN_OFS) begin
      rd_word = {24'h000000, st_r.chan_enable};
    end else begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b0;
    end
    wr_ok = addr_known(st_r.aw_addr);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rxclk_sync = {st_r.rxclk_sync[1:0], rx_clk};
    st_nxt.deliver = 1'b0;
    st_nxt.drop = 1'b0;
    st_nxt.truncate = 1'b0;
    if (s_axi_awvalid && !st_r.aw_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_held && !st_r.bvalid) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_ok ? RXF_RESP_OKAY : RXF_RESP_SLVERR;
      if (st_r.aw_addr == RXF_FILTER_ENABLE_OFS) begin
        st_nxt.rx_filter_enable_reg = merge(st_r.rx_filter_enable_reg, st_r.w_data,
                                            st_r.w_strb);
      end else if (st_r.aw_addr == RXF_MAX_LEN_OFS) begin
        st_nxt.rx_max_frame_length = 16'(merge({16'h0000, st_r.rx_max_frame_length},
                                               st_r.w_data, st_r.w_strb));
      end else if (st_r.aw_addr == RXF_CHAN_EN_OFS) begin
        st_nxt.chan_enable = 8'(merge({24'h000000, st_r.chan_enable}, st_r.w_data,
                                      st_r.w_strb));
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_ok ? RXF_RESP_OKAY : RXF_RESP_SLVERR;
    end
    // Counters are bumped for every overrun kind that fires.
    if (overrun_event) begin
      case (overrun_kind)
        RXF_OVR_FIFO_SOF: st_nxt.start_overrun_counter = st_r.start_overrun_counter + 32'h1;
        RXF_OVR_FIFO_MOF: st_nxt.midframe_overrun_counter =
                            st_r.midframe_overrun_counter + 32'h1;
        RXF_OVR_DMA_SOF: begin
          st_nxt.start_overrun_counter = st_r.start_overrun_counter + 32'h1;
          st_nxt.dma_overrun_counter = st_r.dma_overrun_counter + 32'h1;
        end
        default: begin
          st_nxt.midframe_overrun_counter = st_r.midframe_overrun_counter + 32'h1;
          st_nxt.dma_overrun_counter = st_r.dma_overrun_counter + 32'h1;
        end
      endcase
    end
    case (st_r.state)
      RXF_IDLE: begin
        if (frame_start) begin
          st_nxt.matched = addr_match;
          st_nxt.ctl = frame_is_control;
          st_nxt.dest_ch = frame_dest_channel;
          st_nxt.overrun_seen = 1'b0;
          if (overrun_event && (overrun_kind == RXF_OVR_FIFO_SOF ||
                                overrun_kind == RXF_OVR_DMA_SOF)) begin
            st_nxt.state = RXF_DROP;
          end else begin
            st_nxt.state = RXF_FRAME;
          end
        end
      end
      RXF_FRAME: begin
        // At or past maximum length the frame is cut instead of overrun.
        if (frame_length >= st_r.rx_max_frame_length) begin
          st_nxt.truncate = 1'b1;
        end else if (overrun_event) begin
          st_nxt.overrun_seen = 1'b1;
        end
        if (frame_end) begin
          st_nxt.state = RXF_IDLE;
          st_nxt.ovr_flag = st_r.overrun_seen;
          st_nxt.desc_unmatched_flag_flag = !st_r.matched;
          // Overrun frames survive only with accept-error, plus accept-all if unmatched.
          if (st_r.overrun_seen) begin
            st_nxt.deliver = cef && (st_r.matched || caf);
          end else begin
            st_nxt.deliver = admit;
          end
          st_nxt.drop = !st_nxt.deliver;
          st_nxt.channel = st_r.matched ? st_r.dest_ch : prom_ch;
          st_nxt.last_decision = {16'h0000, 5'h00, st_nxt.channel, 4'h0,
                                  st_nxt.desc_unmatched_flag_flag, st_nxt.ovr_flag,
                                  st_nxt.drop, st_nxt.deliver};
        end
      end
      default: begin
        if (frame_end) begin
          st_nxt.state = RXF_IDLE;
          st_nxt.drop = 1'b1;
        end
      end
    endcase
    if (!st_r.matched && st_r.state == RXF_FRAME && frame_end) begin
      st_nxt.channel = prom_ch;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.rx_filter_enable_reg <= RXF_FILTER_ENABLE_RST;
      st_r.rx_max_frame_length <= RXF_MAX_LEN_RST;
      st_r.chan_enable <= RXF_CHAN_EN_RST;
      st_r.state <= RXF_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign frame_deliver = st_r.deliver;
  assign frame_drop = st_r.drop;
  assign frame_channel = st_r.channel;
  assign desc_overrun_flag = st_r.ovr_flag;
  assign desc_unmatched_flag = st_r.desc_unmatched_flag_flag;
  assign frame_truncate = st_r.truncate;
  assign rx_clk_rise = st_r.rxclk_sync[1] && !st_r.rxclk_sync[2];

endmodule // rxf_filter
